//--- pgc_capture_top.v
// Bank of twelve timestamp capture units with an AXI4-Lite register slave.
// Assumes a running time-of-day input with a tick on each update.
//
// Overview of operation
// [R1] Twelve capture units, each on selectable pin
// [R2] Enabled event stores current precision time value
// [R3] Two held samples, kept until read
// [R4] Sample split: seconds, nanoseconds, sub-nanosecond
// [R5] Sub-nanosecond code 0..4, 8 ns steps
// [R6] Host adds sub-nanosecond offset to time
// [R7] Twelfth unit holds eight samples
// [R8] Cascaded units take overflow events in order
// [R9] Single edge type lands in slot one
// [R10] Both edges: pulse fills slots one, two
// [R11] Config bit 6 enables falling edges
// [R12] Config bit 7 enables rising edges
// [R13] Config bits 11:8 pick the pin
// [R14] Per-unit interrupt enable bit in shared register
// [R15] Per-unit enable bit; disabled captures nothing
// [R16] Capture logic timed by the fast clock
// [R17] Reading releases slots; full unit discards
// [R18] Pins synchronised, then compared with previous
`timescale 1ns/10ps
`include "pgc_consts.vh"

module pgc_capture_top (
  input wire clock,
  input wire sys_rst,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [`PGC_PINS-1:0] gpio_in,
  input wire [`PGC_SEC_W-1:0] ptp_seconds,
  input wire [`PGC_NS_W-1:0] ptp_nanosec,
  input wire ptp_time_tick,
  output reg capture_irq
);

  localparam RD_IDLE = 4'b0001;
  localparam RD_ADDR = 4'b0010;
  localparam RD_DATA = 4'b0100;
  localparam RD_RESP = 4'b1000;

  // First memory slot of a unit
  function [4:0] mem_base;
    input [3:0] unit;
    begin
      mem_base = {unit, 1'b0};
    end
  endfunction

  // Number of slots a unit owns
  function [3:0] unit_cap;
    input [3:0] unit;
    begin
      unit_cap = (unit == `PGC_DEEP_UNIT) ? `PGC_CAP_DEEP : `PGC_CAP_STD; // [R3] [R7]
    end
  endfunction

  // Byte-lane merge of a write into an old value
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer b;
    begin
      lane_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          lane_merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  reg [`PGC_UNITS-1:0] unit_en;
  reg [`PGC_UNITS-1:0] irq_en;
  reg [`PGC_SUB_W-1:0] sub_code;
  reg aw_held;
  reg w_held;
  reg [11:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg [3:0] rd_state;
  reg [11:0] rd_addr;
  reg [3:0] next_rd_state;

  wire [`PGC_PINS-1:0] pin_rise;
  wire [`PGC_PINS-1:0] pin_fall;
  wire [`PGC_UNITS-1:0] mem_we;
  wire [`PGC_UNITS*5-1:0] mem_waddr;
  wire [`PGC_UNITS*`PGC_TS_W-1:0] mem_wdata;
  wire [`PGC_TS_W-1:0] mem_rdata;
  wire [`PGC_UNITS*32-1:0] cfg_flat;
  wire [`PGC_UNITS*4-1:0] count_flat;
  wire [`PGC_UNITS-1:0] fwd_valid;
  wire [`PGC_UNITS*4-1:0] fwd_hops;
  wire [`PGC_UNITS*`PGC_TS_W-1:0] fwd_time;
  wire [`PGC_UNITS-1:0] nonempty;
  wire [`PGC_TS_W-1:0] ts_now;
  wire wr_fire;
  wire [31:0] reg_wval;

  // Sample address fields of the pending read
  wire rd_is_sample = (rd_addr[11:10] != 2'h0);
  wire [3:0] rd_unit = rd_addr[11:8] - 4'h4;
  wire [2:0] rd_sample = rd_addr[7:5];
  wire [2:0] rd_word = rd_addr[4:2];
  wire rd_sample_ok = rd_is_sample && ({1'b0, rd_sample} < unit_cap(rd_unit))
    && (rd_word <= `PGC_W_SUB) && (rd_addr[1:0] == 2'h0);
  wire [3:0] rd_unit_count = count_flat[rd_unit*4 +: 4];
  wire [3:0] rd_page_idx = rd_addr[5:2];
  wire rd_page_ok = (rd_page_idx < 4'hC) && (rd_addr[11:6] != 6'h00);
  wire release_fire = (rd_state == RD_DATA) && rd_sample_ok && (rd_word == `PGC_W_SUB)
    && (rd_unit_count != 4'h0) && ({1'b0, rd_sample} == rd_unit_count - 4'h1);
  wire [4:0] mem_raddr = mem_base(rd_unit) + {2'b00, rd_sample};

  // Synchronised pin edges
  pgc_edge_detect edge_u (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in(gpio_in),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  // Shared sample store
  pgc_sample_mem mem_u (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(mem_raddr),
    .rd_data(mem_rdata)
  );

  // Sub-nanosecond code: clock periods since the last time update, saturating
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sub_code <= 3'h0;
    end else if (ptp_time_tick) begin
      sub_code <= 3'h0; // [R16]
    end else if (sub_code < `PGC_SUB_MAX) begin
      sub_code <= sub_code + 3'h1; // [R5]
    end
  end

  assign ts_now = {ptp_seconds, ptp_nanosec, sub_code}; // [R4]

  // Capture units
  genvar u;
  generate
    for (u = 0; u < `PGC_UNITS; u = u + 1) begin : unit_g
      localparam [3:0] UID = u;
      localparam PREV = (u == 0) ? `PGC_UNITS - 1 : u - 1;
      localparam [11:0] CFG_ADDR = {`PGC_ADDR_CFG_PAGE, UID, 2'b00};
      reg [31:0] cfg;
      reg [3:0] count;
      reg fwd_v;
      reg [3:0] fwd_h;
      reg [`PGC_TS_W-1:0] fwd_t;
      wire [3:0] pin_sel = cfg[`PGC_CFG_PIN_LO +: 4]; // [R13]
      wire local_hit = unit_en[u] & ((cfg[`PGC_CFG_RISE] & pin_rise[pin_sel]) // [R12] [R15]
        | (cfg[`PGC_CFG_FALL] & pin_fall[pin_sel])); // [R11]
      wire take_fwd = fwd_valid[PREV] & unit_en[u]; // [R8]
      wire evt = take_fwd | local_hit;
      wire [`PGC_TS_W-1:0] evt_time = take_fwd ? fwd_time[PREV*`PGC_TS_W +: `PGC_TS_W] : ts_now;
      wire [3:0] evt_hops = take_fwd ? fwd_hops[PREV*4 +: 4] + 4'h1 : 4'h0;
      wire unit_release = release_fire && (rd_unit == UID);
      wire [3:0] base_cnt = unit_release ? 4'h0 : count; // [R17]
      wire room = base_cnt < unit_cap(UID);

      // Slots fill in arrival order: lone edge in slot one, pulse in one then two
      assign mem_we[u] = evt & room; // [R2] [R9] [R10]
      assign mem_waddr[u*5 +: 5] = mem_base(UID) + {1'b0, base_cnt}; // [R3]
      assign mem_wdata[u*`PGC_TS_W +: `PGC_TS_W] = evt_time;
      assign cfg_flat[u*32 +: 32] = cfg;
      assign count_flat[u*4 +: 4] = count;
      assign fwd_valid[u] = fwd_v;
      assign fwd_hops[u*4 +: 4] = fwd_h;
      assign fwd_time[u*`PGC_TS_W +: `PGC_TS_W] = fwd_t;
      assign nonempty[u] = (count != 4'h0);

      // Fill count, with a release in the same cycle clearing it before the new event counts
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          count <= 4'h0;
        end else begin
          count <= base_cnt + {3'b000, mem_we[u]}; // [R17]
        end
      end

      // Overflow passes to the next unit when cascaded, else it is dropped
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          fwd_v <= 1'b0;
          fwd_h <= 4'h0;
          fwd_t <= 65'h0;
        end else begin
          fwd_v <= evt & ~room & cfg[`PGC_CFG_CASCADE] & (evt_hops < `PGC_MAX_HOPS); // [R8]
          fwd_h <= evt_hops;
          fwd_t <= evt_time;
        end
      end

      // Configuration word of this unit
      always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          cfg <= `PGC_CFG_RESET;
        end else if (wr_fire && (wr_addr == CFG_ADDR)) begin
          cfg <= reg_wval & `PGC_CFG_MASK; // [R1]
        end
      end
    end
  endgenerate

  // Write channel: address and data are taken independently
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign reg_wval = lane_merge(32'h0, wr_data, wr_strb);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 12'h000;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PGC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ((wr_addr == `PGC_ADDR_UNIT_EN) || (wr_addr == `PGC_ADDR_IRQ_EN)
            || ((wr_addr[11:6] == `PGC_ADDR_CFG_PAGE) && (wr_addr[5:2] < 4'hC)
            && (wr_addr[1:0] == 2'h0))) begin
          s_axi_bresp <= `PGC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `PGC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Enable words with the written byte lanes laid over their old values
  wire [31:0] unit_en_merged = lane_merge({20'h00000, unit_en}, wr_data, wr_strb);
  wire [31:0] irq_en_merged = lane_merge({20'h00000, irq_en}, wr_data, wr_strb);

  // Shared enable registers, merged by byte lanes
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      unit_en <= `PGC_EN_RESET;
      irq_en <= `PGC_EN_RESET;
    end else if (wr_fire) begin
      if (wr_addr == `PGC_ADDR_UNIT_EN) begin
        unit_en <= unit_en_merged[11:0]; // [R15]
      end
      if (wr_addr == `PGC_ADDR_IRQ_EN) begin
        irq_en <= irq_en_merged[11:0]; // [R14]
      end
    end
  end

  // Interrupt request: any enabled unit holding samples
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      capture_irq <= 1'b0;
    end else begin
      capture_irq <= |(irq_en & nonempty); // [R14]
    end
  end

  // Read sequencer: address, memory read, data build, answer
  assign s_axi_arready = (rd_state == RD_IDLE);
  assign s_axi_rvalid = (rd_state == RD_RESP);

  always @* begin
    case (rd_state)
      RD_IDLE: next_rd_state = s_axi_arvalid ? RD_ADDR : RD_IDLE;
      RD_ADDR: next_rd_state = RD_DATA;
      RD_DATA: next_rd_state = RD_RESP;
      RD_RESP: next_rd_state = s_axi_rready ? RD_IDLE : RD_RESP;
      default: next_rd_state = RD_IDLE;
    endcase
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state <= RD_IDLE;
      rd_addr <= 12'h000;
    end else begin
      rd_state <= next_rd_state;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
      end
    end
  end

  // Read data: a sample is read as five words, seconds and nanoseconds each split high and low, then the sub-nanosecond code
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PGC_RESP_OKAY;
    end else if (rd_state == RD_DATA) begin
      s_axi_rresp <= `PGC_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (rd_addr == `PGC_ADDR_UNIT_EN) begin
        s_axi_rdata <= {20'h00000, unit_en};
      end else if (rd_addr == `PGC_ADDR_IRQ_EN) begin
        s_axi_rdata <= {20'h00000, irq_en};
      end else if (rd_addr == `PGC_ADDR_STATUS) begin
        s_axi_rdata <= {20'h00000, nonempty};
      end else if (rd_page_ok && (rd_addr[11:6] == `PGC_ADDR_CFG_PAGE)) begin
        s_axi_rdata <= cfg_flat[rd_page_idx*32 +: 32];
      end else if (rd_page_ok && (rd_addr[11:6] == `PGC_ADDR_COUNT_PAGE)) begin
        s_axi_rdata <= {28'h0000000, count_flat[rd_page_idx*4 +: 4]};
      end else if (rd_sample_ok) begin
        case (rd_word) // [R4]
          `PGC_W_SEC_HI: s_axi_rdata <= {16'h0000, mem_rdata[64:49]};
          `PGC_W_SEC_LO: s_axi_rdata <= {16'h0000, mem_rdata[48:33]};
          `PGC_W_NS_HI: s_axi_rdata <= {18'h00000, mem_rdata[32:19]};
          `PGC_W_NS_LO: s_axi_rdata <= {16'h0000, mem_rdata[18:3]};
          `PGC_W_SUB: s_axi_rdata <= {29'h00000000, mem_rdata[2:0]}; // [R5] [R6]
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else begin
        s_axi_rresp <= `PGC_RESP_SLVERR;
      end
    end
  end

endmodule

//--- pgc_consts.vh
// Constants of the timestamp capture bank: sizes, field positions, map.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef PGC_CONSTS_VH
`define PGC_CONSTS_VH

// Bank geometry
`define PGC_UNITS 12
`define PGC_PINS 16
`define PGC_SLOTS 30
`define PGC_DEEP_UNIT 4'hB
`define PGC_CAP_STD 4'h2
`define PGC_CAP_DEEP 4'h8
`define PGC_MAX_HOPS 4'hB

// Captured time layout: seconds, nanoseconds, sub-nanosecond code
`define PGC_TS_W 65
`define PGC_SEC_W 32
`define PGC_NS_W 30
`define PGC_SUB_W 3
`define PGC_SUB_MAX 3'h4

// Unit configuration fields
`define PGC_CFG_CASCADE 0
`define PGC_CFG_FALL 6
`define PGC_CFG_RISE 7
`define PGC_CFG_PIN_LO 8
`define PGC_CFG_MASK 32'h00000FC1
`define PGC_CFG_RESET 32'h00000000

// Register byte addresses
`define PGC_ADDR_UNIT_EN 12'h000
`define PGC_ADDR_IRQ_EN 12'h004
`define PGC_ADDR_STATUS 12'h008
`define PGC_ADDR_CFG_PAGE 6'h01
`define PGC_ADDR_COUNT_PAGE 6'h02
`define PGC_EN_RESET 12'h000

// Sample word select within one sample
`define PGC_W_SEC_HI 3'h0
`define PGC_W_SEC_LO 3'h1
`define PGC_W_NS_HI 3'h2
`define PGC_W_NS_LO 3'h3
`define PGC_W_SUB 3'h4

// Bus answers
`define PGC_RESP_OKAY 2'h0
`define PGC_RESP_SLVERR 2'h2

`endif

//--- pgc_edge_detect.v
// Pin synchroniser and edge detector for the general-purpose inputs.
// Assumes the pins are asynchronous to the capture clock.
`timescale 1ns/10ps
`include "pgc_consts.vh"

module pgc_edge_detect (
  input wire clock,
  input wire sys_rst,
  input wire [`PGC_PINS-1:0] pin_in,
  output wire [`PGC_PINS-1:0] pin_rise,
  output wire [`PGC_PINS-1:0] pin_fall
);

  reg [`PGC_PINS-1:0] sync_first;
  reg [`PGC_PINS-1:0] sync_second;
  reg [`PGC_PINS-1:0] pin_prev;

  // Two-stage synchroniser, then one stage of history
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync_first <= 16'h0000;
      sync_second <= 16'h0000;
      pin_prev <= 16'h0000;
    end else begin
      sync_first <= pin_in; // [R18]
      sync_second <= sync_first;
      pin_prev <= sync_second;
    end
  end

  // Compare the settled level with the previous one
  genvar p;
  generate
    for (p = 0; p < `PGC_PINS; p = p + 1) begin : edge_g
      assign pin_rise[p] = sync_second[p] & ~pin_prev[p]; // [R18]
      assign pin_fall[p] = ~sync_second[p] & pin_prev[p];
    end
  endgenerate

endmodule

//--- pgc_sample_mem.v
// Sample store for all capture units, one write port per unit.
// Assumes units never write the same slot in one cycle.
`timescale 1ns/10ps
`include "pgc_consts.vh"

module pgc_sample_mem (
  input wire clock,
  input wire sys_rst,
  input wire [`PGC_UNITS-1:0] wr_en,
  input wire [`PGC_UNITS*5-1:0] wr_addr,
  input wire [`PGC_UNITS*`PGC_TS_W-1:0] wr_data,
  input wire [4:0] rd_addr,
  output reg [`PGC_TS_W-1:0] rd_data
);

  reg [`PGC_TS_W-1:0] mem [0:`PGC_SLOTS-1];
  integer i;

  // Each unit owns its own slot range, so the ports never collide
  always @(posedge clock) begin
    for (i = 0; i < `PGC_UNITS; i = i + 1) begin
      if (wr_en[i]) begin
        mem[wr_addr[i*5 +: 5]] <= wr_data[i*`PGC_TS_W +: `PGC_TS_W];
      end
    end
  end

  // Registered read port
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 65'h0;
    end else if (rd_addr < 5'h1E) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= 65'h0;
    end
  end

endmodule

//--- pgc_capture_properties.sv
// Bus and capture checks on the ports of the capture bank top.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps

module pgc_capture_checker (
  input wire clock,
  input wire sys_rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire capture_irq
);
  reg [11:0] rd_addr_q;

  // Remembers the address of the read under way
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      rd_addr_q <= 12'h000;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  wr_resp_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  rd_latency_a: assert property (ar_taken |=> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read data not three cycles after request");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not released");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response not released");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during read");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  sub_range_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 &&
    rd_addr_q[11:10] != 2'h0 && rd_addr_q[4:2] == 3'h4 |-> s_axi_rdata <= 32'h4)
    else $error("sub-nanosecond code above four");
  rst_idle_a: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !capture_irq)
    else $error("outputs busy after reset");
endmodule

bind pgc_capture_top pgc_capture_checker u_chk (.clock, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .capture_irq);

//--- pgc_pin_source.sv
// Event source on the general-purpose pins.
// Assumes the bench calls pulse from one process at a time.
`timescale 1ns/10ps

module pgc_pin_source (
  input wire clock,
  output reg [15:0] gpio_in
);
  initial gpio_in = 16'h0000;
  // Time at which the last pulse went high
  time rise_at = 0;

  // High pulse of width cycles, then as long low; pin changes are driven on rising clock edges
  task pulse(input [3:0] pin, input [7:0] width);
    begin
      @(posedge clock);
      gpio_in[pin] <= 1'b1;
      rise_at = $time;
      repeat (width) @(posedge clock);
      gpio_in[pin] <= 1'b0;
      repeat (width) @(posedge clock);
    end
  endtask
endmodule

//--- ptp_gpio_timestamp_capture_tb.sv
// Self-checking bench for the timestamp capture bank.
// Assumes the checker is bound to the top and pins come from the source model.
`timescale 1ns/10ps

module ptp_gpio_timestamp_capture_tb;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h000;
  reg s_axi_awvalid = 1'b0;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg s_axi_wvalid = 1'b0;
  reg s_axi_bready = 1'b0;
  reg [11:0] s_axi_araddr = 12'h000;
  reg s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0;
  reg [29:0] ptp_nanosec = 30'h0;
  reg ptp_time_tick = 1'b0;
  reg [1:0] phase = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] gpio_in;
  integer err_total = 0;
  integer check_count = 0;
  integer i;
  reg [31:0] t0, t1, t2, t3, t4, rd, ra, rb;
  reg [1:0] rs;

  // Capture clock
  always #5 clock = ~clock;
  // Time of day: 40 ns per update; the tick stands in the cycle before each update
  always @(posedge clock) begin
    phase <= phase + 2'h1;
    ptp_time_tick <= (phase == 2'h2);
    if (phase == 2'h3) ptp_nanosec <= ptp_nanosec + 30'h28;
  end

  pgc_pin_source u_pins (.clock(clock), .gpio_in(gpio_in));
  pgc_capture_top u_dut (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .gpio_in(gpio_in), .ptp_seconds(32'h00012345),
    .ptp_nanosec(ptp_nanosec), .ptp_time_tick(ptp_time_tick), .capture_irq(capture_irq));

  task conclude;
    begin
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Compare within a tolerance; zero tolerance means exact
  task chk(input [31:0] got, input [31:0] exp, input [31:0] tol);
    begin
      check_count = check_count + 1;
      if ((^got === 1'bx) || (tol == 0 && got !== exp) || got + tol < exp || got > exp + tol) begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Bus write; sampled mid-cycle, released just after the taking edge
  task wr(input [11:0] a, input [31:0] d, output [1:0] r);
    integer n;
    reg ta, tw, tb;
    begin
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      for (n = 0; n < 64 && !tb; n = n + 1) begin
        @(negedge clock);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clock);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
      end
      if (!tb) begin
        err_total = err_total + 1;
        conclude;
      end
    end
  endtask

  // Bus read
  task rd_reg(input [11:0] a, output [31:0] d, output [1:0] r);
    integer n;
    reg ta, tr;
    begin
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      for (n = 0; n < 64 && !tr; n = n + 1) begin
        @(negedge clock);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clock);
        if (ta) s_axi_arvalid <= 1'b0;
        if (tr) s_axi_rready <= 1'b0;
      end
      if (!tr) begin
        err_total = err_total + 1;
        conclude;
      end
    end
  endtask

  task cnt(input [3:0] u, input [31:0] e);
    begin
      rd_reg(12'h080 + {6'h00, u, 2'h0}, rd, rs);
      chk(rd, e, 0);
    end
  endtask

  // Reads one sample; returns nanoseconds plus the sub-nanosecond offset
  task get_time(input [3:0] u, input [2:0] s, output [31:0] t);
    reg [11:0] b;
    reg [31:0] hi, lo, sub;
    begin
      b = 12'h400 + {u, 8'h00} + {4'h0, s, 5'h00};
      rd_reg(b, rd, rs);
      chk(rd, 32'h0001, 0);
      rd_reg(b + 12'h004, rd, rs);
      chk(rd, 32'h2345, 0);
      rd_reg(b + 12'h008, hi, rs);
      rd_reg(b + 12'h00C, lo, rs);
      rd_reg(b + 12'h010, sub, rs);
      t = {2'h0, hi[13:0], lo[15:0]} + {sub[28:0], 3'h0};
    end
  endtask

  // Reset values, unmapped place, disabled units
  task t_map;
    begin
      rd_reg(12'h000, rd, rs);
      chk(rd, 32'h0, 0);
      rd_reg(12'h00C, rd, rs);
      chk({30'h0, rs}, 32'h2, 0);
      wr(12'h00C, 32'hFFFFFFFF, rs);
      chk({30'h0, rs}, 32'h2, 0);
      wr(12'h040, 32'h00000380, rs);
      wr(12'h044, 32'h00000340, rs);
      wr(12'h048, 32'h000003C0, rs);
      rd_reg(12'h048, rd, rs);
      chk(rd, 32'h000003C0, 0);
      u_pins.pulse(4'h3, 8'h14);
      for (i = 0; i < 3; i = i + 1)
        cnt(i[3:0], 32'h0);
    end
  endtask

  // Edge kinds, full units, release and interrupt
  task t_edges;
    begin
      wr(12'h000, 32'h00000007, rs);
      u_pins.pulse(4'h4, 8'h14);
      cnt(4'h0, 32'h0);
      u_pins.pulse(4'h3, 8'h14);
      ra = u_pins.rise_at[31:0];
      cnt(4'h0, 32'h1);
      cnt(4'h1, 32'h1);
      cnt(4'h2, 32'h2);
      rd_reg(12'h008, rd, rs);
      chk(rd, 32'h7, 0);
      chk({31'h0, capture_irq}, 32'h0, 0);
      wr(12'h004, 32'h00000002, rs);
      repeat (4) @(negedge clock);
      chk({31'h0, capture_irq}, 32'h1, 0);
      u_pins.pulse(4'h3, 8'h14);
      rb = u_pins.rise_at[31:0];
      u_pins.pulse(4'h3, 8'h14);
      cnt(4'h0, 32'h2);
      cnt(4'h2, 32'h2);
      get_time(4'h0, 3'h0, t0);
      get_time(4'h1, 3'h0, t2);
      get_time(4'h2, 3'h0, t3);
      get_time(4'h2, 3'h1, t4);
      get_time(4'h0, 3'h1, t1);
      chk(t1 - t0, rb - ra, 32'hA);
      chk(t2 - t0, 32'hC8, 32'hA);
      chk(t3, t0, 32'hA);
      chk(t4 - t3, 32'hC8, 32'hA);
      rd_reg(12'h530, rd, rs);
      for (i = 0; i < 3; i = i + 1)
        cnt(i[3:0], 32'h0);
      chk({31'h0, capture_irq}, 32'h0, 0);
      u_pins.pulse(4'h3, 8'h14);
      cnt(4'h0, 32'h1);
    end
  endtask

  // Deep unit holds eight, then refuses
  task t_deep;
    begin
      wr(12'h06C, 32'h00000780, rs);
      wr(12'h000, 32'h00000800, rs);
      for (i = 0; i < 9; i = i + 1)
        u_pins.pulse(4'h7, 8'h04);
      cnt(4'hB, 32'h8);
      get_time(4'hB, 3'h0, t0);
      get_time(4'hB, 3'h7, t1);
      chk(t1 - t0, 32'h276, 32'hA);
      cnt(4'hB, 32'h0);
    end
  endtask

  // Cascaded pair on one pin
  task t_cascade;
    begin
      wr(12'h050, 32'h00000981, rs);
      wr(12'h054, 32'h00000900, rs);
      wr(12'h000, 32'h00000030, rs);
      for (i = 0; i < 3; i = i + 1)
        u_pins.pulse(4'h9, 8'h04);
      cnt(4'h4, 32'h2);
      cnt(4'h5, 32'h1);
      rd_reg(12'h008, rd, rs);
      chk(rd, 32'h37, 0);
    end
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_map;
    t_edges;
    t_deep;
    t_cascade;
    conclude;
  end
endmodule
